//--- src/mif_pkg.sv
// Package: constants, register indices and layout of the maskable interrupt flag bank
// Notes on behaviour
// - Request flag sets on its source event or on a software write of 1.
// - Request flag clears on acknowledge, on reset, or on a software write of 0.
// - Request bytes take bit and byte writes; low pair also as word; reset 00H.
// - Each source owns one request, one mask and one priority flag, in three bytes.
// - Watchdog flags act as interrupt control only in interval timer mode.
// - Watchdog request flag is readable and writable only in interval timer mode.
// - Watchdog mask read in watchdog mode 1 is undefined; nothing relies on it.
// - Mask flag of 1 blocks both servicing and standby release for that source.
// - Mask bytes take bit and byte writes; low pair also as word; reset FFH.
// - A shared port pin in output mode still sets its request flag on change.
// - Priority bytes take bit, byte and low-pair word writes; reset FFH.
// - A request is eligible only with request flag 1 and mask flag 0.
// - Pick by priority flag first, then default order, source 0 highest.
package mif_pkg;
	localparam int MIF_NSRC = 24;
	localparam int MIF_IDX_W = 5;
	// Register indices on the flag register port
	localparam logic [3:0] MIF_REQ_L = 4'h0;
	localparam logic [3:0] MIF_REQ_H = 4'h1;
	localparam logic [3:0] MIF_REQ_1 = 4'h2;
	localparam logic [3:0] MIF_MSK_L = 4'h3;
	localparam logic [3:0] MIF_MSK_H = 4'h4;
	localparam logic [3:0] MIF_MSK_1 = 4'h5;
	localparam logic [3:0] MIF_PRI_L = 4'h6;
	localparam logic [3:0] MIF_PRI_H = 4'h7;
	localparam logic [3:0] MIF_PRI_1 = 4'h8;
	localparam logic [7:0] MIF_REQ_RST = 8'h00;
	localparam logic [7:0] MIF_MSK_RST = 8'hFF;
	localparam logic [7:0] MIF_PRI_RST = 8'hFF;
	// Watchdog source sits at bit 0 of the first byte
	localparam int MIF_WDT_BIT = 0;
	typedef enum logic [1:0] {
		MIF_SZ_BIT = 2'b00,
		MIF_SZ_BYTE = 2'b01,
		MIF_SZ_WORD = 2'b10
	} mif_size_e;
endpackage : mif_pkg

//--- src/mif_sel_if.sv
// Interface: flag vectors from the bank to the request selector and its answer
`timescale 1ns/100ps
interface mif_sel_if;
	logic [23:0] req;
	logic [23:0] msk;
	logic [23:0] pri;
	logic valid;
	logic [4:0] idx;
	logic idx_pri;
	modport bank (output req, output msk, output pri, input valid, input idx, input idx_pri);
	modport sel (input req, input msk, input pri, output valid, output idx, output idx_pri);
endinterface : mif_sel_if

//--- src/mif_select.sv
// Selector: eligible request with the best priority, then the lowest source number
`timescale 1ns/100ps
module mif_select
	import mif_pkg::*;
(
	mif_sel_if.sel s
);
	logic [23:0] elig;
	logic [23:0] cand;
	logic hi_any;
	assign elig = s.req & ~s.msk;
	always_comb begin
		// Priority flag 0 is the high level; ties fall to the fixed order
		hi_any = |(elig & ~s.pri);
		cand = hi_any ? (elig & ~s.pri) : elig;
		s.valid = |elig;
		s.idx = 5'h00;
		s.idx_pri = 1'b1;
		for (int i = MIF_NSRC - 1; i >= 0; i--) begin
			if (cand[i]) begin
				s.idx = i[4:0];
				s.idx_pri = s.pri[i];
			end
		end
	end
endmodule : mif_select

//--- src/mif_bank.sv
// Top: 24-source request, mask and priority flag bank with CPU register port
`timescale 1ns/100ps
module mif_bank
	import mif_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// Source event lines, one cycle pulses, bit n is source n
	input wire logic [23:0] i_event,
	// Watchdog runs as interval timer
	input wire logic i_wdt_interval,
	// CPU register port
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [3:0] i_idx,
	input wire logic [1:0] i_size,
	input wire logic [2:0] i_bit,
	input wire logic [15:0] i_wdata,
	output logic [15:0] o_rdata,
	// Acknowledge from the CPU core
	input wire logic i_ack,
	input wire logic [4:0] i_ack_idx,
	// Request towards the CPU core
	output logic o_irq,
	output logic [4:0] o_irq_idx,
	output logic o_irq_pri,
	output logic o_wake,
	// Flag vectors for observation
	output logic [23:0] o_req,
	output logic [23:0] o_msk,
	output logic [23:0] o_pri
);
	logic [23:0] req;
	logic [23:0] msk;
	logic [23:0] pri;
	logic [23:0] wmask;
	logic [23:0] wval;
	logic [23:0] req_we;
	logic [23:0] msk_we;
	logic [23:0] pri_we;
	logic [23:0] ack_clr;
	logic [23:0] ev_set;
	logic [23:0] req_eff;
	logic [15:0] next_rdata;
	logic [1:0] grp;
	mif_sel_if sel_bus ();

	////////////////////////////////////////////////////////////////////////
	// Write decode: bit, byte, or word on the low pair
	always_comb begin
		wmask = 24'h000000;
		wval = 24'h000000;
		grp = 2'b00;
		case (i_idx)
			MIF_REQ_L, MIF_MSK_L, MIF_PRI_L: grp = 2'b00;
			MIF_REQ_H, MIF_MSK_H, MIF_PRI_H: grp = 2'b01;
			MIF_REQ_1, MIF_MSK_1, MIF_PRI_1: grp = 2'b10;
			default: grp = 2'b11;
		endcase
		case (mif_size_e'(i_size))
			MIF_SZ_BIT: begin
				if (grp != 2'b11) begin
					wmask[{grp, i_bit}] = 1'b1;
					wval[{grp, i_bit}] = i_wdata[0];
				end
			end
			MIF_SZ_BYTE: begin
				if (grp != 2'b11) begin
					wmask[{grp, 3'b000} +: 8] = 8'hFF;
					wval[{grp, 3'b000} +: 8] = i_wdata[7:0];
				end
			end
			MIF_SZ_WORD: begin
				// Word access pairs the low and high bytes of group 0 only
				if (grp == 2'b00) begin
					wmask[15:0] = 16'hFFFF;
					wval[15:0] = i_wdata;
				end
			end
			default: wmask = 24'h000000;
		endcase
		if (!i_wr) begin
			wmask = 24'h000000;
		end
		// Watchdog request bit takes no software write outside interval timer mode
		if (!i_wdt_interval) begin
			wmask[MIF_WDT_BIT] = wmask[MIF_WDT_BIT] & (i_idx > MIF_REQ_1);
		end
	end

	assign req_we = (i_idx <= MIF_REQ_1) ? wmask : 24'h000000;
	assign msk_we = (i_idx >= MIF_MSK_L && i_idx <= MIF_MSK_1) ? wmask : 24'h000000;
	assign pri_we = (i_idx >= MIF_PRI_L && i_idx <= MIF_PRI_1) ? wmask : 24'h000000;

	////////////////////////////////////////////////////////////////////////
	// Request flags
	always_comb begin
		ev_set = i_event;
		// Watchdog event counts as maskable only in interval timer mode
		ev_set[MIF_WDT_BIT] = i_event[MIF_WDT_BIT] & i_wdt_interval;
		ack_clr = 24'h000000;
		if (i_ack) begin
			ack_clr[i_ack_idx] = 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			req <= {3{MIF_REQ_RST}};
		end else begin
			// Event set is applied last so it wins over a clear
			req <= (((req & ~ack_clr) & ~req_we) | (wval & req_we)) | ev_set;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			msk <= {3{MIF_MSK_RST}};
		end else begin
			// Stored mask is returned as is; callers must not rely on the watchdog bit
			msk <= (msk & ~msk_we) | (wval & msk_we);
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			pri <= {3{MIF_PRI_RST}};
		end else begin
			pri <= (pri & ~pri_we) | (wval & pri_we);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Selection and outputs
	always_comb begin
		req_eff = req;
		req_eff[MIF_WDT_BIT] = req[MIF_WDT_BIT] & i_wdt_interval;
	end
	assign sel_bus.req = req_eff;
	assign sel_bus.msk = msk;
	assign sel_bus.pri = pri;

	mif_select u_sel (
		.s(sel_bus.sel)
	);

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_irq <= 1'b0;
			o_irq_idx <= 5'h00;
			o_irq_pri <= 1'b1;
			o_wake <= 1'b0;
		end else begin
			// Withdrawn the cycle after acknowledge, as the flag clears
			o_irq <= sel_bus.valid & ~i_ack;
			o_irq_idx <= sel_bus.idx;
			o_irq_pri <= sel_bus.idx_pri;
			o_wake <= sel_bus.valid;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_req <= 24'h000000;
			o_msk <= 24'hFFFFFF;
			o_pri <= 24'hFFFFFF;
		end else begin
			o_req <= req;
			o_msk <= msk;
			o_pri <= pri;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data, registered one cycle after the read strobe
	always_comb begin
		next_rdata = 16'h0000;
		case (i_idx)
			MIF_REQ_L: next_rdata = (i_size == MIF_SZ_WORD) ? req[15:0] : {8'h00, req[7:0]};
			MIF_REQ_H: next_rdata = {8'h00, req[15:8]};
			MIF_REQ_1: next_rdata = {8'h00, req[23:16]};
			MIF_MSK_L: next_rdata = (i_size == MIF_SZ_WORD) ? msk[15:0] : {8'h00, msk[7:0]};
			MIF_MSK_H: next_rdata = {8'h00, msk[15:8]};
			MIF_MSK_1: next_rdata = {8'h00, msk[23:16]};
			MIF_PRI_L: next_rdata = (i_size == MIF_SZ_WORD) ? pri[15:0] : {8'h00, pri[7:0]};
			MIF_PRI_H: next_rdata = {8'h00, pri[15:8]};
			MIF_PRI_1: next_rdata = {8'h00, pri[23:16]};
			default: next_rdata = 16'h0000;
		endcase
		// Watchdog request reads as 0 outside interval timer mode
		if (i_idx == MIF_REQ_L && !i_wdt_interval) begin
			next_rdata[MIF_WDT_BIT] = 1'b0;
		end
		if (i_size == MIF_SZ_BIT) begin
			next_rdata = {15'h0000, next_rdata[i_bit]};
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_rdata <= 16'h0000;
		end else if (i_rd) begin
			o_rdata <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	set_wins_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(i_event[5] && req_we[5] && !wval[5]) |=> req[5])
		else $error("event lost against clear");
	ack_clear_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(i_ack && i_ack_idx == 5'd3 && !i_event[3] && !(req_we[3] && wval[3])) |=> !req[3])
		else $error("ack did not clear flag");
	event_set_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		i_event[9] |=> req[9])
		else $error("event did not set flag");
	mask_block_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(o_irq && o_irq_idx == 5'd7) |-> $past(req_eff[7] && !msk[7]))
		else $error("masked source requested");
	wake_gate_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		$past(msk) == 24'hFFFFFF |-> !o_wake)
		else $error("wake while all masked");
	word_write_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(i_wr && i_idx == MIF_MSK_L && i_size == MIF_SZ_WORD) |=> msk[15:0] == $past(i_wdata))
		else $error("mask word write lost");
	pri_bytes_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(i_wr && i_idx == MIF_PRI_1 && i_size == MIF_SZ_BYTE) |=> pri[23:16] == $past(i_wdata[7:0]))
		else $error("priority byte write lost");
	wdt_frozen_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(!i_wdt_interval && !i_ack) |=> req[0] == $past(req[0]))
		else $error("watchdog flag moved outside interval mode");
	prio_pick_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(sel_bus.valid && |(req_eff & ~msk & ~pri)) |-> !sel_bus.idx_pri)
		else $error("low priority chosen over high");
endmodule : mif_bank

//--- bench/mif_cpu_model.sv
// CPU core stand-in that acknowledges the pending request
`timescale 1ns/100ps
module mif_cpu_model (
	// Clock and enable
	input wire logic i_clk,
	input wire logic i_auto,
	// Request from the bank
	input wire logic i_irq,
	input wire logic [4:0] i_irq_idx,
	// Acknowledge towards the bank
	output logic o_ack,
	output logic [4:0] o_ack_idx
);
	initial begin
		o_ack = 1'b0;
		o_ack_idx = 5'h00;
	end
	// Idle one cycle after each pulse so the stale request is never acknowledged twice
	always @(posedge i_clk) begin
		#1;
		if (o_ack) begin
			o_ack = 1'b0;
			o_ack_idx = ~o_ack_idx;
		end else if (i_auto && i_irq) begin
			o_ack = 1'b1;
			o_ack_idx = i_irq_idx;
		end
	end
endmodule : mif_cpu_model

//--- bench/maskable_interrupt_flag_bank_bench.sv
// Bench: register traffic, events, arbitration and acknowledge of the flag bank
`timescale 1ns/100ps
module maskable_interrupt_flag_bank_bench;
	import mif_pkg::*;
	logic i_clk, i_rstn, i_wdt_interval, i_wr, i_rd, i_ack, o_irq, o_irq_pri, o_wake, auto;
	logic [23:0] i_event, o_req, o_msk, o_pri, er, em, ep, ev;
	logic [3:0] i_idx, x;
	logic [1:0] i_size;
	logic [2:0] i_bit;
	logic [15:0] i_wdata, o_rdata, d, v;
	logic [4:0] i_ack_idx, o_irq_idx;
	logic [31:0] seed;
	int miscompares, checks, k, t;
	mif_bank u_mif_bank (.i_clk(i_clk), .i_rstn(i_rstn), .i_event(i_event),
		.i_wdt_interval(i_wdt_interval), .i_wr(i_wr), .i_rd(i_rd), .i_idx(i_idx),
		.i_size(i_size), .i_bit(i_bit), .i_wdata(i_wdata), .o_rdata(o_rdata),
		.i_ack(i_ack), .i_ack_idx(i_ack_idx), .o_irq(o_irq), .o_irq_idx(o_irq_idx),
		.o_irq_pri(o_irq_pri), .o_wake(o_wake), .o_req(o_req), .o_msk(o_msk), .o_pri(o_pri));
	mif_cpu_model u_mif_cpu_model (.i_clk(i_clk), .i_auto(auto), .i_irq(o_irq),
		.i_irq_idx(o_irq_idx), .o_ack(i_ack), .o_ack_idx(i_ack_idx));
	initial begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	// High priority level first, then lowest source number
	function automatic logic [4:0] pick(input logic [23:0] r, m, p);
		for (int n = 0; n < 24; n++) if (r[n] && !m[n] && !p[n]) return n[4:0];
		for (int n = 0; n < 24; n++) if (r[n] && !m[n]) return n[4:0];
		return 5'h00;
	endfunction : pick
	task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : tick
	// One register access; ev rides along as a same-cycle event pulse
	task automatic acc(input logic w, input logic [3:0] ix, input logic [1:0] s,
		input logic [2:0] b, input logic [15:0] val);
		@(posedge i_clk);
		#1;
		i_wr = w;
		i_rd = !w;
		i_idx = ix;
		i_size = s;
		i_bit = b;
		i_wdata = val;
		i_event = ev;
		@(posedge i_clk);
		#1;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_event = 24'h000000;
		d = o_rdata;
	endtask : acc
	task automatic stop_test;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : stop_test
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{i_rstn, i_wr, i_rd, auto, i_idx, i_size, i_bit, i_wdata} = '0;
		i_event = 24'h000000;
		ev = 24'h000000;
		i_wdt_interval = 1'b1;
		seed = 32'h0d84ed74;
		repeat (8) @(posedge i_clk);
		#1;
		i_rstn = 1'b1;
		for (k = 0; k < 9; k++) begin
			acc(1'b0, k[3:0], MIF_SZ_BYTE, 3'h0, 16'h0000);
			chk(d[7:0], k < 3 ? 8'h00 : 8'hFF, "reset");
		end
		$display("test reset done");
		for (k = 0; k < 30; k++) begin
			seed = lfsr(seed);
			x = 4'(seed[11:8] % 4'h9);
			acc(1'b1, x, MIF_SZ_BYTE, 3'h0, {8'h00, seed[7:0]});
			acc(1'b0, x, MIF_SZ_BYTE, 3'h0, 16'h0000);
			chk(d[7:0], seed[7:0], "byte");
		end
		for (k = 0; k < 3; k++) begin
			seed = lfsr(seed);
			v = seed[15:0];
			x = 4'(k * 3);
			acc(1'b1, x, MIF_SZ_WORD, 3'h0, v);
			acc(1'b1, x + 4'h1, MIF_SZ_WORD, 3'h0, ~v);
			acc(1'b0, x, MIF_SZ_WORD, 3'h0, 16'h0000);
			chk(d, v, "word");
			acc(1'b0, x + 4'h1, MIF_SZ_BYTE, 3'h0, 16'h0000);
			chk(d[7:0], v[15:8], "high");
		end
		acc(1'b1, 4'h9, MIF_SZ_BYTE, 3'h0, 16'h00FF);
		acc(1'b0, 4'h9, MIF_SZ_BYTE, 3'h0, 16'h0000);
		chk(d, 16'h0000, "unmapped");
		$display("test access done");
		acc(1'b1, MIF_REQ_1, MIF_SZ_BIT, 3'h5, 16'h0001);
		acc(1'b0, MIF_REQ_1, MIF_SZ_BIT, 3'h5, 16'h0000);
		chk(d[0], 1'b1, "bit set");
		acc(1'b1, MIF_REQ_1, MIF_SZ_BIT, 3'h5, 16'h0000);
		acc(1'b0, MIF_REQ_1, MIF_SZ_BIT, 3'h5, 16'h0000);
		chk(d[0], 1'b0, "bit clr");
		ev = 24'h000020;
		acc(1'b1, MIF_REQ_L, MIF_SZ_BIT, 3'h5, 16'h0000);
		ev = 24'h000000;
		acc(1'b0, MIF_REQ_L, MIF_SZ_BIT, 3'h5, 16'h0000);
		chk(d[0], 1'b1, "set wins");
		// Earlier word writes leave the watchdog flag random; start it from 0
		acc(1'b1, MIF_REQ_L, MIF_SZ_BIT, 3'h0, 16'h0000);
		i_wdt_interval = 1'b0;
		acc(1'b1, MIF_REQ_L, MIF_SZ_BIT, 3'h0, 16'h0001);
		ev = 24'h000001;
		acc(1'b0, MIF_REQ_L, MIF_SZ_BIT, 3'h0, 16'h0000);
		ev = 24'h000000;
		chk(d[0], 1'b0, "wdt write");
		tick(2);
		chk(o_req[0], 1'b0, "wdt event");
		i_wdt_interval = 1'b1;
		acc(1'b1, MIF_REQ_L, MIF_SZ_BIT, 3'h0, 16'h0001);
		i_wdt_interval = 1'b0;
		acc(1'b0, MIF_REQ_L, MIF_SZ_BIT, 3'h0, 16'h0000);
		chk(d[0], 1'b0, "wdt hidden");
		acc(1'b1, MIF_REQ_L, MIF_SZ_BIT, 3'h0, 16'h0000);
		tick(1);
		chk(o_req[0], 1'b1, "wdt frozen");
		i_wdt_interval = 1'b1;
		$display("test flags done");
		acc(1'b1, MIF_REQ_L, MIF_SZ_WORD, 3'h0, 16'h0000);
		acc(1'b1, MIF_REQ_1, MIF_SZ_BYTE, 3'h0, 16'h0000);
		for (k = 0; k < 12; k++) begin
			seed = lfsr(seed);
			er = seed[23:0];
			seed = lfsr(seed);
			em = seed[23:0];
			seed = lfsr(seed);
			ep = seed[23:0];
			acc(1'b1, MIF_MSK_L, MIF_SZ_WORD, 3'h0, em[15:0]);
			acc(1'b1, MIF_MSK_1, MIF_SZ_BYTE, 3'h0, {8'h00, em[23:16]});
			acc(1'b1, MIF_PRI_L, MIF_SZ_WORD, 3'h0, ep[15:0]);
			acc(1'b1, MIF_PRI_1, MIF_SZ_BYTE, 3'h0, {8'h00, ep[23:16]});
			ev = er;
			acc(1'b0, 4'h9, MIF_SZ_BYTE, 3'h0, 16'h0000);
			ev = 24'h000000;
			tick(2);
			chk(o_req, er, "events");
			chk(o_irq, |(er & ~em), "irq");
			chk(o_wake, |(er & ~em), "wake");
			chk(o_msk, em, "masks");
			chk(o_pri, ep, "prios");
			if (|(er & ~em)) begin
				chk(o_irq_idx, pick(er, em, ep), "winner");
				chk(o_irq_pri, ep[pick(er, em, ep)], "level");
			end
			auto = 1'b1;
			for (t = 0; t < 100 && |(o_req & ~em); t++) tick(1);
			auto = 1'b0;
			if (t == 100) begin
				miscompares++;
				$display("FAIL %0t acknowledge hang", $time);
				break;
			end
			tick(3);
			chk(o_req, er & em, "ack clears");
			acc(1'b1, MIF_REQ_L, MIF_SZ_WORD, 3'h0, 16'h0000);
			acc(1'b1, MIF_REQ_1, MIF_SZ_BYTE, 3'h0, 16'h0000);
		end
		$display("test arbitration done");
		stop_test();
	end
endmodule : maskable_interrupt_flag_bank_bench
